//--- verilog/clbs_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the
//          cache/local-bus control and pin-strap register bank.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef CLBS_REGS_SVH
`define CLBS_REGS_SVH

// ----------------------------------------------------------------------------
// I/O port pair (low byte of the I/O address)
// ----------------------------------------------------------------------------
`define CLBS_IO_INDEX_ADDR 8'h22
`define CLBS_IO_DATA_ADDR 8'h23

// ----------------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------------
`define CLBS_IDX_MISC 8'h14
`define CLBS_IDX_STRAP 8'h20

// ----------------------------------------------------------------------------
// Cache and local-bus misc register fields
// ----------------------------------------------------------------------------
`define CLBS_MISC_LB_RESET_BIT 4
`define CLBS_MISC_LB_EN_BIT 3
`define CLBS_MISC_INVAL_BIT 2
`define CLBS_MISC_WB_BIT 1
`define CLBS_MISC_POLICY_BIT 0
`define CLBS_MISC_LB_RESET_RST 1'b1
`define CLBS_MISC_LB_EN_RST 1'b0
`define CLBS_MISC_POLICY_RST 1'b0

// ----------------------------------------------------------------------------
// Pin strap register fields
// ----------------------------------------------------------------------------
`define CLBS_STRAP_EXTBUF_BIT 3
`define CLBS_STRAP_CARD_BIT 2
`define CLBS_STRAP_WIDTH_MSB 1
`define CLBS_STRAP_WIDTH_LSB 0
`define CLBS_STRAP_WIDTH_32 2'h3
`define CLBS_STRAP_WIDTH_16 2'h2

// ----------------------------------------------------------------------------
// Misc values and timing
// ----------------------------------------------------------------------------
`define CLBS_INDEX_RST 8'h00
`define CLBS_UNMAPPED_READ 8'h00
`define CLBS_STRAP_SETTLE 3'h4

`endif

//--- verilog/clbs_pkg.sv
// Purpose: Types shared by the cache/local-bus strap control bank.
// Assumes: Used with package:: prefix, never imported.
// Notes:   One-hot codes written out.
package clbs_pkg;

  // --------------------------------------------------------------------------
  // Strap capture sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLBS_ST_SETTLE = 3'h1,
    CLBS_ST_LATCH = 3'h2,
    CLBS_ST_RUN = 3'h4
  } clbs_strap_state_t;

endpackage : clbs_pkg

//--- verilog/clbs_pin_sync.sv
// Purpose: Three-flop synchroniser for strap pins with agreement filter.
// Assumes: Pins are asynchronous to i_clk.
// Notes:   Output follows only when second and third stages agree.
`timescale 1ns/1ps

module clbs_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins
  input wire logic [WIDTH-1:0] i_pin,
  // Filtered level
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // ---------------------------------------------------------------------------
  // Agreement filter: first stage is read only by the second
  // ---------------------------------------------------------------------------
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  // Shift chain and filtered level
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;

endmodule : clbs_pin_sync

//--- verilog/clbs_ctrl.sv
// Purpose: Cache/local-bus misc register and pin-strap register behind an
//          indexed I/O port pair, with special-cycle status capture.
// Assumes: Special-cycle and core-reset inputs come from logic on i_clk.
// Notes:   Upper misc bits and other indexed registers live elsewhere.
`timescale 1ns/1ps
`include "clbs_regs.svh"

module clbs_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // I/O port access
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // Core bus events
  input wire logic i_inval_cycle,
  input wire logic i_wb_cycle,
  input wire logic i_cpu_reset,
  // Strap pins: [3] buffer avail, [2] card boot, [1:0] rom width
  input wire logic [3:0] i_strap_pin,
  // Local bus control
  output logic o_local_bus_reset,
  output logic o_local_bus_if_enable,
  // Cache control
  output logic o_cache_policy_sel,
  // Boot configuration
  output logic o_ext_buffer_ctl_avail,
  output logic o_boot_to_card_socket,
  output logic o_rom_width_16,
  output logic o_rom_width_32,
  output logic o_rom_low_word_buffer_enable,
  output logic o_strap_valid
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [3:0] strap_level;
  logic [7:0] index_reg;
  logic [7:0] index_next;
  logic local_bus_reset_ctl_reg;
  logic local_bus_reset_ctl_next;
  logic local_bus_if_enable_reg;
  logic local_bus_if_enable_next;
  logic invalidate_cycle_seen_reg;
  logic invalidate_cycle_seen_next;
  logic writeback_cycle_seen_reg;
  logic writeback_cycle_seen_next;
  logic cache_policy_sel_reg;
  logic cache_policy_sel_next;
  logic ext_buffer_ctl_avail_reg;
  logic ext_buffer_ctl_avail_next;
  logic boot_to_card_socket_reg;
  logic boot_to_card_socket_next;
  logic [1:0] boot_rom_width_cfg_reg;
  logic [1:0] boot_rom_width_cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic width16_reg;
  logic width16_next;
  logic width32_reg;
  logic width32_next;
  clbs_pkg::clbs_strap_state_t state_reg;
  clbs_pkg::clbs_strap_state_t state_next;
  logic [2:0] settle_reg;
  logic [2:0] settle_next;
  logic strap_valid_reg;
  logic strap_valid_next;
  logic data_wr;
  logic data_rd;
  logic misc_wr;
  logic misc_rd;
  logic strap_wr;
  logic [7:0] misc_view;
  logic [7:0] strap_view;

  // ---------------------------------------------------------------------------
  // Strap pin synchroniser
  // ---------------------------------------------------------------------------
  clbs_pin_sync #(
    .WIDTH(4)
  ) u_strap_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_strap_pin),
    .o_level(strap_level)
  );

  // ---------------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------------
  // Index port selects, data port reaches the selected register
  assign data_wr = i_io_wr && (i_io_addr == `CLBS_IO_DATA_ADDR);
  assign data_rd = i_io_rd && (i_io_addr == `CLBS_IO_DATA_ADDR);
  assign misc_wr = data_wr && (index_reg == `CLBS_IDX_MISC);
  assign misc_rd = data_rd && (index_reg == `CLBS_IDX_MISC);
  assign strap_wr = data_wr && (index_reg == `CLBS_IDX_STRAP);

  // Register views; upper misc bits and reserved strap bits read zero
  assign misc_view = {3'h0, local_bus_reset_ctl_reg, local_bus_if_enable_reg,
                      invalidate_cycle_seen_reg, writeback_cycle_seen_reg,
                      cache_policy_sel_reg};
  assign strap_view = {4'h0, ext_buffer_ctl_avail_reg, boot_to_card_socket_reg,
                       boot_rom_width_cfg_reg};

  // ---------------------------------------------------------------------------
  // Strap capture sequencer
  // ---------------------------------------------------------------------------
  // Waits for the pin filter to fill before sampling, so a stale reset value
  // of the synchroniser is never taken as the strap
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      clbs_pkg::CLBS_ST_SETTLE: begin
        settle_next = settle_reg + 3'h1;
        if (settle_reg == `CLBS_STRAP_SETTLE) begin
          state_next = clbs_pkg::CLBS_ST_LATCH;
        end
      end
      clbs_pkg::CLBS_ST_LATCH: begin
        state_next = clbs_pkg::CLBS_ST_RUN;
      end
      clbs_pkg::CLBS_ST_RUN: begin
        state_next = clbs_pkg::CLBS_ST_RUN;
      end
      default: begin
        state_next = clbs_pkg::CLBS_ST_SETTLE;
        settle_next = 3'h0;
      end
    endcase
    // Valid flag rises with the strap load; the width decode outputs follow it one cycle later
    strap_valid_next = (state_next == clbs_pkg::CLBS_ST_RUN);
  end

  // Sequencer state, settle count and registered valid flag
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= clbs_pkg::CLBS_ST_SETTLE;
      settle_reg <= 3'h0;
      strap_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      strap_valid_reg <= strap_valid_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Index and misc register
  // ---------------------------------------------------------------------------
  always_comb begin
    index_next = index_reg;
    local_bus_reset_ctl_next = local_bus_reset_ctl_reg;
    local_bus_if_enable_next = local_bus_if_enable_reg;
    invalidate_cycle_seen_next = invalidate_cycle_seen_reg;
    writeback_cycle_seen_next = writeback_cycle_seen_reg;
    cache_policy_sel_next = cache_policy_sel_reg;
    if (i_io_wr && (i_io_addr == `CLBS_IO_INDEX_ADDR)) begin
      index_next = i_io_wdata;
    end
    if (misc_wr) begin
      local_bus_reset_ctl_next = i_io_wdata[`CLBS_MISC_LB_RESET_BIT];
      local_bus_if_enable_next = i_io_wdata[`CLBS_MISC_LB_EN_BIT];
      cache_policy_sel_next = i_io_wdata[`CLBS_MISC_POLICY_BIT];
    end
    // Read clears; status bits take no write data
    if (misc_rd) begin
      invalidate_cycle_seen_next = 1'b0;
      writeback_cycle_seen_next = 1'b0;
    end
    // Event in the clearing cycle still wins
    if (i_inval_cycle) begin
      invalidate_cycle_seen_next = 1'b1;
    end
    if (i_wb_cycle) begin
      writeback_cycle_seen_next = 1'b1;
    end
    // Core reset overrides a same-cycle write
    if (i_cpu_reset) begin
      cache_policy_sel_next = `CLBS_MISC_POLICY_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      index_reg <= `CLBS_INDEX_RST;
      local_bus_reset_ctl_reg <= `CLBS_MISC_LB_RESET_RST;
      local_bus_if_enable_reg <= `CLBS_MISC_LB_EN_RST;
      invalidate_cycle_seen_reg <= 1'b0;
      writeback_cycle_seen_reg <= 1'b0;
      cache_policy_sel_reg <= `CLBS_MISC_POLICY_RST;
    end else begin
      index_reg <= index_next;
      local_bus_reset_ctl_reg <= local_bus_reset_ctl_next;
      local_bus_if_enable_reg <= local_bus_if_enable_next;
      invalidate_cycle_seen_reg <= invalidate_cycle_seen_next;
      writeback_cycle_seen_reg <= writeback_cycle_seen_next;
      cache_policy_sel_reg <= cache_policy_sel_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin strap register
  // ---------------------------------------------------------------------------
  // Strap load beats a software write in the same cycle
  always_comb begin
    ext_buffer_ctl_avail_next = ext_buffer_ctl_avail_reg;
    boot_to_card_socket_next = boot_to_card_socket_reg;
    boot_rom_width_cfg_next = boot_rom_width_cfg_reg;
    if (strap_wr) begin
      boot_to_card_socket_next = i_io_wdata[`CLBS_STRAP_CARD_BIT];
      boot_rom_width_cfg_next =
        i_io_wdata[`CLBS_STRAP_WIDTH_MSB:`CLBS_STRAP_WIDTH_LSB];
    end
    if (state_reg == clbs_pkg::CLBS_ST_LATCH) begin
      ext_buffer_ctl_avail_next = strap_level[`CLBS_STRAP_EXTBUF_BIT];
      boot_to_card_socket_next = strap_level[`CLBS_STRAP_CARD_BIT];
      boot_rom_width_cfg_next =
        strap_level[`CLBS_STRAP_WIDTH_MSB:`CLBS_STRAP_WIDTH_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_buffer_ctl_avail_reg <= 1'b0;
      boot_to_card_socket_reg <= 1'b0;
      boot_rom_width_cfg_reg <= 2'h0;
    end else begin
      ext_buffer_ctl_avail_reg <= ext_buffer_ctl_avail_next;
      boot_to_card_socket_reg <= boot_to_card_socket_next;
      boot_rom_width_cfg_reg <= boot_rom_width_cfg_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data and width decode
  // ---------------------------------------------------------------------------
  // Read data is registered: valid the cycle after the read strobe, held after
  always_comb begin
    rdata_next = rdata_reg;
    if (i_io_rd) begin
      if (i_io_addr == `CLBS_IO_INDEX_ADDR) begin
        rdata_next = index_reg;
      end else if (misc_rd) begin
        rdata_next = misc_view;
      end else if (data_rd && (index_reg == `CLBS_IDX_STRAP)) begin
        rdata_next = strap_view;
      end else begin
        rdata_next = `CLBS_UNMAPPED_READ;
      end
    end
    // Decode lags the field by one cycle so the outputs come from flops
    width16_next = (boot_rom_width_cfg_reg == `CLBS_STRAP_WIDTH_16);
    width32_next = (boot_rom_width_cfg_reg == `CLBS_STRAP_WIDTH_32);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= 8'h00;
      width16_reg <= 1'b0;
      width32_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      width16_reg <= width16_next;
      width32_reg <= width32_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, each straight from a flop
  // ---------------------------------------------------------------------------
  assign o_io_rdata = rdata_reg;
  assign o_local_bus_reset = local_bus_reset_ctl_reg;
  assign o_local_bus_if_enable = local_bus_if_enable_reg;
  assign o_cache_policy_sel = cache_policy_sel_reg;
  assign o_ext_buffer_ctl_avail = ext_buffer_ctl_avail_reg;
  assign o_boot_to_card_socket = boot_to_card_socket_reg;
  assign o_rom_width_16 = width16_reg;
  assign o_rom_width_32 = width32_reg;
  assign o_rom_low_word_buffer_enable = width32_reg;
  // Valid comes from its own flop rather than a state decode at the pin
  assign o_strap_valid = strap_valid_reg;

endmodule : clbs_ctrl

//--- bench/clbs_monitor.sv
// Purpose: Port-level checks for the cache/local-bus strap bank.
// Assumes: Bound to clbs_ctrl; one clock domain.
// Notes:   Index and status bits are shadowed in helper logic.
`timescale 1ns/1ps
`include "clbs_regs.svh"

module clbs_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // I/O port access
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  // Core events and straps
  input wire logic i_inval_cycle,
  input wire logic i_wb_cycle,
  input wire logic i_cpu_reset,
  input wire logic [3:0] i_strap_pin,
  // Controls
  input wire logic o_local_bus_reset,
  input wire logic o_local_bus_if_enable,
  input wire logic o_cache_policy_sel,
  input wire logic o_ext_buffer_ctl_avail,
  input wire logic o_boot_to_card_socket,
  input wire logic o_rom_width_16,
  input wire logic o_rom_width_32,
  input wire logic o_rom_low_word_buffer_enable,
  input wire logic o_strap_valid
);
  logic [7:0] idx_reg, idx_next;
  logic inv_reg, inv_next, wbk_reg, wbk_next;
  logic dat, misc_rd, misc_wr, strap_wr, bad_rd;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Access decode against the shadowed index
  assign dat = (i_io_addr == `CLBS_IO_DATA_ADDR);
  assign misc_rd = i_io_rd && dat && (idx_reg == `CLBS_IDX_MISC);
  assign misc_wr = i_io_wr && dat && (idx_reg == `CLBS_IDX_MISC);
  assign strap_wr = i_io_wr && dat && (idx_reg == `CLBS_IDX_STRAP);
  assign bad_rd = i_io_rd && (i_io_addr != `CLBS_IO_INDEX_ADDR) &&
                  !misc_rd && !(dat && idx_reg == `CLBS_IDX_STRAP);

  // Shadow state; an event in the clearing cycle keeps its bit
  always_comb begin
    idx_next = idx_reg;
    if (i_io_wr && i_io_addr == `CLBS_IO_INDEX_ADDR) begin
      idx_next = i_io_wdata;
    end
    inv_next = i_inval_cycle || (inv_reg && !misc_rd);
    wbk_next = i_wb_cycle || (wbk_reg && !misc_rd);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_reg <= `CLBS_INDEX_RST;
      inv_reg <= 1'b0;
      wbk_reg <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      inv_reg <= inv_next;
      wbk_reg <= wbk_next;
    end
  end

  lb_reset_a: assert property (misc_wr |=> o_local_bus_reset == $past(i_io_wdata[4]))
    else $error("local bus reset differs from written bit");
  lb_enable_a: assert property (misc_wr |=> o_local_bus_if_enable == $past(i_io_wdata[3]))
    else $error("interface enable differs from written bit");
  inval_status_a: assert property (misc_rd && !i_inval_cycle |=>
    o_io_rdata[2] == $past(inv_reg)) else $error("invalidate status read wrong");
  wb_status_a: assert property (misc_rd && !i_wb_cycle |=>
    o_io_rdata[1] == $past(wbk_reg)) else $error("write-back status read wrong");
  policy_write_a: assert property (misc_wr && !i_cpu_reset |=>
    o_cache_policy_sel == $past(i_io_wdata[0])) else $error("policy differs from write");
  core_reset_a: assert property (i_cpu_reset |=> !o_cache_policy_sel)
    else $error("policy not cleared by core reset");
  strap_latch_a: assert property ($rose(o_strap_valid) |->
    o_ext_buffer_ctl_avail == i_strap_pin[3] && o_boot_to_card_socket == i_strap_pin[2])
    else $error("strap bits differ from pins");
  width_decode_a: assert property (strap_wr && o_strap_valid |-> ##2
    o_rom_width_32 == ($past(i_io_wdata[1:0], 2) == 2'h3) &&
    o_rom_width_16 == ($past(i_io_wdata[1:0], 2) == 2'h2) &&
    o_rom_low_word_buffer_enable == o_rom_width_32) else $error("width decode wrong");
  unmapped_read_a: assert property (bad_rd |=> o_io_rdata == `CLBS_UNMAPPED_READ)
    else $error("unmapped read not zero");

  // Main scenarios
  inval_seen_c: cover property (misc_rd && inv_reg);
  wb_seen_c: cover property (misc_rd && wbk_reg);
  core_reset_c: cover property (i_cpu_reset && o_cache_policy_sel);
endmodule : clbs_monitor

bind clbs_ctrl clbs_monitor u_mon (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
  .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
  .i_inval_cycle(i_inval_cycle), .i_wb_cycle(i_wb_cycle), .i_cpu_reset(i_cpu_reset),
  .i_strap_pin(i_strap_pin), .o_local_bus_reset(o_local_bus_reset),
  .o_local_bus_if_enable(o_local_bus_if_enable), .o_cache_policy_sel(o_cache_policy_sel),
  .o_ext_buffer_ctl_avail(o_ext_buffer_ctl_avail),
  .o_boot_to_card_socket(o_boot_to_card_socket), .o_rom_width_16(o_rom_width_16),
  .o_rom_width_32(o_rom_width_32),
  .o_rom_low_word_buffer_enable(o_rom_low_word_buffer_enable),
  .o_strap_valid(o_strap_valid)
);

//--- bench/clbs_core_model.sv
// Purpose: Processor core side: special cycles, core reset, strap pins.
// Assumes: Driven by tasks called from the bench.
// Notes:   Strap pins only move while system reset is held.
`timescale 1ns/1ps

module clbs_core_model (
  // Clock
  input wire logic i_clk,
  // Core events and straps
  output logic o_inval_cycle,
  output logic o_wb_cycle,
  output logic o_cpu_reset,
  output logic [3:0] o_strap_pin
);
  // Quiet core, buffer available, card boot off, 32-bit boot ROM
  initial begin
    o_inval_cycle = 1'b0;
    o_wb_cycle = 1'b0;
    o_cpu_reset = 1'b0;
    o_strap_pin = 4'hb;
  end

  // One-cycle special bus cycle pulses
  task automatic fire(input logic inv, input logic wbk);
    @(posedge i_clk);
    o_inval_cycle <= inv;
    o_wb_cycle <= wbk;
    @(posedge i_clk);
    o_inval_cycle <= 1'b0;
    o_wb_cycle <= 1'b0;
    #1;
  endtask : fire

  // Core reset held for n edges
  task automatic hold_reset(input int n);
    @(posedge i_clk);
    o_cpu_reset <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_cpu_reset <= 1'b0;
    #1;
  endtask : hold_reset

  task automatic set_straps(input logic [3:0] v);
    @(posedge i_clk);
    o_strap_pin <= v;
  endtask : set_straps
endmodule : clbs_core_model

//--- bench/cache_local_bus_strap_control_test.sv
// Purpose: Self-checking bench for the cache/local-bus strap bank.
// Assumes: 20 MHz clock, registers behind the 0x22/0x23 pair.
// Notes:   Each scenario is one task that judges its own results.
`timescale 1ns/1ps
`include "clbs_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module cache_local_bus_strap_control_test;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_io_wr = 1'b0, i_io_rd = 1'b0;
  logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, o_io_rdata, d;
  logic i_inval_cycle, i_wb_cycle, i_cpu_reset, o_local_bus_reset;
  logic o_local_bus_if_enable, o_cache_policy_sel, o_ext_buffer_ctl_avail;
  logic o_boot_to_card_socket, o_rom_width_16, o_rom_width_32, o_rom_low_word_buffer_enable;
  logic o_strap_valid;
  logic [3:0] i_strap_pin;
  int fails = 0, checks = 0;

  always #25 i_clk = ~i_clk;

  clbs_core_model core (.i_clk(i_clk), .o_inval_cycle(i_inval_cycle),
    .o_wb_cycle(i_wb_cycle), .o_cpu_reset(i_cpu_reset), .o_strap_pin(i_strap_pin));

  clbs_ctrl DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_inval_cycle(i_inval_cycle), .i_wb_cycle(i_wb_cycle), .i_cpu_reset(i_cpu_reset),
    .i_strap_pin(i_strap_pin), .o_local_bus_reset(o_local_bus_reset),
    .o_local_bus_if_enable(o_local_bus_if_enable), .o_cache_policy_sel(o_cache_policy_sel),
    .o_ext_buffer_ctl_avail(o_ext_buffer_ctl_avail),
    .o_boot_to_card_socket(o_boot_to_card_socket), .o_rom_width_16(o_rom_width_16),
    .o_rom_width_32(o_rom_width_32),
    .o_rom_low_word_buffer_enable(o_rom_low_word_buffer_enable),
    .o_strap_valid(o_strap_valid));

  // --------------------------------------------------------------------------
  // Port access tasks: strobe for one edge, data read after the next
  // --------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_io_addr <= a;
    i_io_wdata <= v;
    i_io_wr <= 1'b1;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_io_addr <= a;
    i_io_rd <= 1'b1;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    #1;
    v = o_io_rdata;
  endtask : rd

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
    wr(`CLBS_IO_INDEX_ADDR, idx);
    wr(`CLBS_IO_DATA_ADDR, v);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] v);
    wr(`CLBS_IO_INDEX_ADDR, idx);
    rd(`CLBS_IO_DATA_ADDR, v);
  endtask : reg_rd

  // Bounded wait for the strap latch, then one edge for the decode
  task automatic wait_straps();
    for (int i = 0; i < 20 && o_strap_valid !== 1'b1; i++) begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    #1;
  endtask : wait_straps

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_vals();
    wait_straps();
    `CHK(o_strap_valid, 1'b1)
    `CHK(o_local_bus_reset, 1'b1)
    `CHK(o_local_bus_if_enable, 1'b0)
    `CHK(o_cache_policy_sel, 1'b0)
    reg_rd(`CLBS_IDX_MISC, d);
    `CHK(d, 8'h10)
    reg_rd(`CLBS_IDX_STRAP, d);
    `CHK(d, 8'h0b)
    `CHK({o_rom_width_32, o_rom_low_word_buffer_enable}, 2'h3)
  endtask : t_reset_vals

  // Enable only ever changes with the local bus held in reset
  task automatic t_local_bus();
    reg_wr(`CLBS_IDX_MISC, 8'h18);
    `CHK({o_local_bus_reset, o_local_bus_if_enable}, 2'h3)
    reg_wr(`CLBS_IDX_MISC, 8'h08);
    `CHK({o_local_bus_reset, o_local_bus_if_enable}, 2'h1)
    reg_wr(`CLBS_IDX_MISC, 8'h18);
    reg_wr(`CLBS_IDX_MISC, 8'h10);
    `CHK({o_local_bus_reset, o_local_bus_if_enable}, 2'h2)
  endtask : t_local_bus

  task automatic t_events();
    core.fire(1'b1, 1'b0);
    reg_rd(`CLBS_IDX_MISC, d);
    `CHK(d[2:1], 2'h2)
    rd(`CLBS_IO_DATA_ADDR, d);
    `CHK(d[2:1], 2'h0)
    core.fire(1'b0, 1'b1);
    rd(`CLBS_IO_DATA_ADDR, d);
    `CHK(d[2:1], 2'h1)
    core.hold_reset(2);
    reg_wr(`CLBS_IDX_MISC, 8'h16);
    rd(`CLBS_IO_DATA_ADDR, d);
    `CHK(d, 8'h10)
    core.fire(1'b1, 1'b1);
    rd(`CLBS_IO_DATA_ADDR, d);
    `CHK(d[2:1], 2'h3)
  endtask : t_events

  // Every width code, with the read-only availability bit written low
  task automatic t_strap();
    for (int c = 0; c < 4; c++) begin
      reg_wr(`CLBS_IDX_STRAP, {4'hf, 1'b0, c[1], c[1:0]});
      rd(`CLBS_IO_DATA_ADDR, d);
      `CHK(d, {4'h0, 1'b1, c[1], c[1:0]})
      `CHK(o_boot_to_card_socket, c[1])
      `CHK({o_rom_width_16, o_rom_width_32}, {c == 2, c == 3})
      `CHK(o_rom_low_word_buffer_enable, c == 3)
    end
  endtask : t_strap

  task automatic t_unmapped();
    rd(8'h40, d);
    `CHK(d, `CLBS_UNMAPPED_READ)
    reg_wr(8'h15, 8'hff);
    rd(`CLBS_IO_DATA_ADDR, d);
    `CHK(d, `CLBS_UNMAPPED_READ)
    reg_rd(`CLBS_IDX_MISC, d);
    `CHK(d, 8'h10)
    rd(`CLBS_IO_INDEX_ADDR, d);
    `CHK(d, `CLBS_IDX_MISC)
  endtask : t_unmapped

  // Policy set, core reset, write-through switch, then system reset mid-run
  task automatic t_policy();
    reg_wr(`CLBS_IDX_MISC, 8'h11);
    `CHK(o_cache_policy_sel, 1'b1)
    core.hold_reset(3);
    `CHK(o_cache_policy_sel, 1'b0)
    reg_wr(`CLBS_IDX_MISC, 8'h11);
    reg_wr(`CLBS_IDX_MISC, 8'h10);
    core.fire(1'b0, 1'b1);
    `CHK(o_cache_policy_sel, 1'b0)
    reg_wr(`CLBS_IDX_MISC, 8'h11);
    i_arst_n <= 1'b0;
    core.set_straps(4'h6);
    @(posedge i_clk);
    #1;
    `CHK(o_cache_policy_sel, 1'b0)
    `CHK(o_strap_valid, 1'b0)
    i_arst_n <= 1'b1;
    wait_straps();
    `CHK({o_ext_buffer_ctl_avail, o_boot_to_card_socket}, 2'h1)
    `CHK({o_rom_width_16, o_rom_width_32}, 2'h2)
  endtask : t_policy

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Main sequence: five-cycle reset, then each scenario in turn
  initial begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset_vals();
    t_local_bus();
    t_events();
    t_strap();
    t_unmapped();
    t_policy();
    close_out();
  end

  // Watchdog: the scenarios need well under 1000 cycles
  initial begin
    #(3000 * 50);
    fails++;
    close_out();
  end
endmodule : cache_local_bus_strap_control_test
